//--- fcu_pkg.sv
package fcu_pkg;

	// Register offsets
	localparam logic [7:0] FILTER_SEL_OFFS = 8'h19;
	localparam logic [7:0] SYNC_OFFS       = 8'h1D;
	localparam logic [7:0] INDEX_OFFS      = 8'h32;
	localparam logic [7:0] WORD_OFFS       = 8'h33;
	localparam logic [7:0] UNLOCK_OFFS     = 8'h34;

	// Register widths and values after reset
	localparam int         REG_W          = 8;
	localparam int         COEF_W         = 24;
	localparam logic [7:0] FILTER_SEL_RST = 8'h00;
	localparam logic [7:0] SYNC_RST       = 8'h80;
	localparam logic [7:0] INDEX_RST      = 8'h00;
	localparam logic [23:0] WORD_RST      = 24'h000000;

	// Filter selection field
	localparam int         FILT_TYPE_LSB  = 4;
	localparam int         FILT_TYPE_W    = 3;
	localparam logic [2:0] FILT_TYPE_PROG = 3'h4;

	// Unlock key bytes
	localparam logic [7:0] KEY_FIRST  = 8'hAC;
	localparam logic [7:0] KEY_SECOND = 8'h45;
	localparam logic [7:0] KEY_EXIT   = 8'h55;

	// Index control fields and the user taps bit of the data word
	localparam int ACCESS_BIT    = 7;
	localparam int WRITE_BIT     = 6;
	localparam int INDEX_W       = 6;
	localparam int USER_TAPS_BIT = 23;

	// Coefficient store and mirrored tap count
	localparam int COEF_DEPTH = 56;
	localparam int TAP_COUNT  = 112;
	localparam int TAP_W      = 7;

	// Settling interval, in master clock periods; master clock is core_clk
	localparam int CORE_CLK_HZ       = 100_000_000;
	localparam int MCLK_HZ           = CORE_CLK_HZ;
	localparam int WAIT_MCLK_PERIODS = 512;
	localparam int WAIT_CYC          = WAIT_MCLK_PERIODS * (CORE_CLK_HZ / MCLK_HZ);
	localparam int WAIT_CNT_W        = 10;

	// Key sequence states
	typedef enum logic [1:0] {
		FCU_KEY_LOCKED,
		FCU_KEY_HALF,
		FCU_KEY_OPEN
	} fcu_key_t;

endpackage

//--- fcu_mem_if.sv
`timescale 1ns/1ps
interface fcu_mem_if #(
	parameter int WIDTH = 24,
	parameter int AW    = 6
);
	logic             wr_en;
	logic [AW-1:0]    wr_addr;
	logic [WIDTH-1:0] wr_data;
	logic [AW-1:0]    host_addr;
	logic [WIDTH-1:0] host_data;
	logic [AW-1:0]    tap_addr;
	logic [WIDTH-1:0] tap_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data, output host_addr,
		input host_data, output tap_addr, input tap_data);
	modport store (input wr_en, input wr_addr, input wr_data, input host_addr,
		output host_data, input tap_addr, output tap_data);
endinterface

//--- fcu_coef_mem.sv
`timescale 1ns/1ps
module fcu_coef_mem #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 56,
	parameter int AW    = 6
) (
	// Clock, reset, enable
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic ce,
	// Access port
	fcu_mem_if.store  mem
);
	logic [WIDTH-1:0] cell_q [DEPTH];

	// One flop row per coefficient entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_cell
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				cell_q[i] <= '0;
			end else if (ce && mem.wr_en && (mem.wr_addr == AW'(i))) begin
				cell_q[i] <= mem.wr_data;
			end
		end
	end

	// Reads beyond the store return zero
	always_comb begin
		mem.host_data = (int'(mem.host_addr) < DEPTH) ? cell_q[mem.host_addr] : '0;
		mem.tap_data  = (int'(mem.tap_addr) < DEPTH) ? cell_q[mem.tap_addr] : '0;
	end
endmodule // fcu_coef_mem

//--- fcu_top.sv
`timescale 1ns/1ps
module fcu_top #(
	parameter int COEF_DEPTH = fcu_pkg::COEF_DEPTH
) (
	// Clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [23:0] reg_wdata,
	output logic      [23:0] reg_rdata,
	output logic             reg_rvalid,
	// Filter path tap fetch
	input  wire logic [6:0]  tap_sel,
	output logic      [23:0] tap_coef,
	// Status
	output logic      [2:0]  filter_type,
	output logic             prog_filter_sel,
	output logic             key_open,
	output logic             user_taps_enable,
	output logic             taps_active_user,
	output logic             sync_pulse,
	output logic             settle_busy
);
	localparam int AW = fcu_pkg::INDEX_W;
	localparam int CW = fcu_pkg::COEF_W;

	// Refuse a store the index field cannot reach
	if (COEF_DEPTH < 1 || COEF_DEPTH > (1 << AW) || 2 * COEF_DEPTH > (1 << fcu_pkg::TAP_W))
	begin : g_depth_check
		$error("fcu_top: COEF_DEPTH out of range");
	end

	fcu_mem_if #(.WIDTH(CW), .AW(AW)) mem_bus ();

	fcu_coef_mem #(
		.WIDTH (CW),
		.DEPTH (COEF_DEPTH),
		.AW    (AW)
	) u_mem (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.mem      (mem_bus.store)
	);

	// Register state
	logic [7:0]              filter_sel_q;
	logic [7:0]              sync_reg_q;
	logic [7:0]              index_ctrl_q;
	logic [CW-1:0]           coef_word_q;
	fcu_pkg::fcu_key_t       key_q;
	fcu_pkg::fcu_key_t       key_d;
	logic                    user_taps_q;
	logic [fcu_pkg::WAIT_CNT_W-1:0] wait_cnt_q;

	// Decoded strobes
	logic wr_filter;
	logic wr_sync;
	logic wr_index;
	logic wr_word;
	logic wr_unlock;
	logic prog_sel;
	logic unlocked;
	logic gate_ok;
	logic new_access;
	logic new_write;
	logic cur_access;
	logic cur_write;
	logic [AW-1:0] new_index;
	logic [AW-1:0] cur_index;

	assign wr_filter = ce && reg_wr && (reg_addr == fcu_pkg::FILTER_SEL_OFFS);
	assign wr_sync   = ce && reg_wr && (reg_addr == fcu_pkg::SYNC_OFFS);
	assign wr_index  = ce && reg_wr && (reg_addr == fcu_pkg::INDEX_OFFS);
	assign wr_word   = ce && reg_wr && (reg_addr == fcu_pkg::WORD_OFFS);
	assign wr_unlock = ce && reg_wr && (reg_addr == fcu_pkg::UNLOCK_OFFS);

	// Programmable filter must be selected before memory opens
	assign prog_sel = filter_sel_q[fcu_pkg::FILT_TYPE_LSB +: fcu_pkg::FILT_TYPE_W]
		== fcu_pkg::FILT_TYPE_PROG;
	assign unlocked = (key_q == fcu_pkg::FCU_KEY_OPEN);
	assign gate_ok  = unlocked && prog_sel;

	// Index fields, current and as being written
	assign new_access = reg_wdata[fcu_pkg::ACCESS_BIT];
	assign new_write  = reg_wdata[fcu_pkg::WRITE_BIT];
	assign new_index  = reg_wdata[AW-1:0];
	assign cur_access = index_ctrl_q[fcu_pkg::ACCESS_BIT];
	assign cur_write  = index_ctrl_q[fcu_pkg::WRITE_BIT];
	assign cur_index  = index_ctrl_q[AW-1:0];

	// Key sequence next state
	always_comb begin
		key_d = key_q;
		if (wr_unlock) begin
			case (key_q)
				fcu_pkg::FCU_KEY_LOCKED: begin
					if (reg_wdata[7:0] == fcu_pkg::KEY_FIRST) begin
						key_d = fcu_pkg::FCU_KEY_HALF;
					end
				end
				fcu_pkg::FCU_KEY_HALF: begin
					if (reg_wdata[7:0] == fcu_pkg::KEY_SECOND) begin
						key_d = fcu_pkg::FCU_KEY_OPEN;
					end else if (reg_wdata[7:0] != fcu_pkg::KEY_FIRST) begin
						key_d = fcu_pkg::FCU_KEY_LOCKED;
					end
				end
				fcu_pkg::FCU_KEY_OPEN: begin
					if (reg_wdata[7:0] == fcu_pkg::KEY_EXIT) begin
						key_d = fcu_pkg::FCU_KEY_LOCKED;
					end
				end
				default: begin
					key_d = fcu_pkg::FCU_KEY_LOCKED;
				end
			endcase
		end
	end

	// Key state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			key_q    <= fcu_pkg::FCU_KEY_LOCKED;
			key_open <= 1'b0;
		end else if (ce) begin
			key_q    <= key_d;
			key_open <= (key_d == fcu_pkg::FCU_KEY_OPEN);
		end
	end

	// Filter selection and sync registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			filter_sel_q    <= fcu_pkg::FILTER_SEL_RST;
			sync_reg_q      <= fcu_pkg::SYNC_RST;
			filter_type     <= fcu_pkg::FILTER_SEL_RST[fcu_pkg::FILT_TYPE_LSB +: 3];
			prog_filter_sel <= 1'b0;
		end else if (ce) begin
			if (wr_filter) begin
				filter_sel_q    <= reg_wdata[7:0];
				filter_type     <= reg_wdata[fcu_pkg::FILT_TYPE_LSB +: fcu_pkg::FILT_TYPE_W];
				prog_filter_sel <= reg_wdata[fcu_pkg::FILT_TYPE_LSB +: fcu_pkg::FILT_TYPE_W]
					== fcu_pkg::FILT_TYPE_PROG;
			end
			if (wr_sync) begin
				sync_reg_q <= reg_wdata[7:0];
			end
		end
	end

	// Index control register; access bits drop when the key closes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			index_ctrl_q <= fcu_pkg::INDEX_RST;
		end else if (ce) begin
			if (wr_index) begin
				index_ctrl_q <= reg_wdata[7:0];
			end else if (key_d != fcu_pkg::FCU_KEY_OPEN) begin
				index_ctrl_q[fcu_pkg::ACCESS_BIT] <= 1'b0;
				index_ctrl_q[fcu_pkg::WRITE_BIT]  <= 1'b0;
			end
		end
	end

	// Memory write and host read addressing
	always_comb begin
		mem_bus.wr_en     = 1'b0;
		mem_bus.wr_addr   = cur_index;
		mem_bus.wr_data   = coef_word_q;
		mem_bus.host_addr = wr_index ? new_index : cur_index;
		if (wr_index && gate_ok && new_access && new_write) begin
			mem_bus.wr_en   = 1'b1;
			mem_bus.wr_addr = new_index;
			mem_bus.wr_data = coef_word_q;
		end else if (wr_word && gate_ok && cur_access && cur_write) begin
			mem_bus.wr_en   = 1'b1;
			mem_bus.wr_addr = cur_index;
			mem_bus.wr_data = reg_wdata;
		end
	end

	// Data register: written value, or fetched for read-only access
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			coef_word_q <= fcu_pkg::WORD_RST;
		end else if (ce) begin
			if (wr_word && gate_ok && cur_access) begin
				if (cur_write) begin
					coef_word_q <= reg_wdata;
				end
			end else if (wr_index && gate_ok && new_access && !new_write) begin
				coef_word_q <= mem_bus.host_data;
			end
		end
	end

	// User taps enable, set by a data write with the key open, outside memory access
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			user_taps_q      <= 1'b0;
			user_taps_enable <= 1'b0;
		end else if (ce) begin
			if (wr_word && unlocked && !cur_access) begin
				user_taps_q      <= reg_wdata[fcu_pkg::USER_TAPS_BIT];
				user_taps_enable <= reg_wdata[fcu_pkg::USER_TAPS_BIT];
			end
		end
	end

	// Sync pulse; taps in use follow the enable at each sync while the programmable filter is selected
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_pulse       <= 1'b0;
			taps_active_user <= 1'b0;
		end else if (ce) begin
			sync_pulse <= wr_sync;
			if (wr_sync) begin
				taps_active_user <= user_taps_q && prog_sel;
			end
		end
	end

	// Settling window after an index write or a data access
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_cnt_q  <= '0;
			settle_busy <= 1'b0;
		end else if (ce) begin
			if (wr_index || wr_word || (reg_rd && reg_addr == fcu_pkg::WORD_OFFS)) begin
				wait_cnt_q  <= fcu_pkg::WAIT_CNT_W'(fcu_pkg::WAIT_CYC - 1);
				settle_busy <= 1'b1;
			end else if (wait_cnt_q != '0) begin
				wait_cnt_q <= wait_cnt_q - 1'b1;
			end else begin
				settle_busy <= 1'b0;
			end
		end
	end

	// Tap fetch: upper half mirrors the stored half
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tap_coef <= '0;
		end else if (ce) begin
			tap_coef <= mem_bus.tap_data;
		end
	end

	always_comb begin
		if (int'(tap_sel) < COEF_DEPTH) begin
			mem_bus.tap_addr = tap_sel[AW-1:0];
		end else begin
			mem_bus.tap_addr = AW'(2 * COEF_DEPTH - 1 - int'(tap_sel));
		end
	end

	// Register reads, answered one cycle after the strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					fcu_pkg::FILTER_SEL_OFFS: reg_rdata <= {16'h0000, filter_sel_q};
					fcu_pkg::SYNC_OFFS:       reg_rdata <= {16'h0000, sync_reg_q};
					fcu_pkg::INDEX_OFFS:      reg_rdata <= {16'h0000, index_ctrl_q};
					fcu_pkg::WORD_OFFS: begin
						if (gate_ok && cur_access) begin
							reg_rdata <= mem_bus.host_data;
						end else begin
							reg_rdata <= {user_taps_q, 23'h000000};
						end
					end
					fcu_pkg::UNLOCK_OFFS:     reg_rdata <= {23'h000000, unlocked};
					default:                  reg_rdata <= '0;
				endcase
			end
		end
	end

endmodule // fcu_top

//--- fcu_top_props.sv
`timescale 1ns/1ps
module fcu_top_props #(
	parameter int COEF_DEPTH = 56
) (
	// Clock, reset, enable
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        ce,
	// Register port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic        reg_rvalid,
	// Status
	input wire logic [2:0]  filter_type,
	input wire logic        prog_filter_sel,
	input wire logic        key_open,
	input wire logic        user_taps_enable,
	input wire logic        taps_active_user,
	input wire logic        sync_pulse,
	input wire logic        settle_busy
);
	logic        wr_ok;
	logic [10:0] busy_cnt_q;
	// Write strobe that the port really takes
	assign wr_ok = ce & reg_wr;
	// Length of the current busy stretch
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			busy_cnt_q <= 11'h000;
		else if (ce)
			busy_cnt_q <= settle_busy ? busy_cnt_q + 11'h001 : 11'h000;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
		else $error("read answer missing");
	a_read_cause: assert property (reg_rvalid |-> $past(ce && reg_rd))
		else $error("read answer without request");
	a_filter_field: assert property (wr_ok && reg_addr == 8'h19 |=> filter_type == $past(reg_wdata[6:4]))
		else $error("filter type not taken");
	a_prog_select: assert property (prog_filter_sel == (filter_type == 3'h4))
		else $error("programmable select wrong");
	a_key_open: assert property ($rose(key_open) |-> $past(wr_ok && reg_addr == 8'h34 && reg_wdata[7:0] == 8'h45))
		else $error("key opened without second byte");
	a_key_lock: assert property (wr_ok && reg_addr == 8'h34 && reg_wdata[7:0] == 8'h55 |=> !key_open)
		else $error("exit byte did not lock");
	a_settle_len: assert property ($fell(settle_busy) |-> busy_cnt_q == 11'd512)
		else $error("busy stretch not 512 cycles");
	a_user_taps: assert property ($rose(user_taps_enable) |-> $past(wr_ok && reg_addr == 8'h33 && reg_wdata[23]))
		else $error("user taps set without data write");
	a_sync_pulse: assert property (wr_ok && reg_addr == 8'h1D |=> sync_pulse ##1 !sync_pulse)
		else $error("sync pulse wrong");
	a_taps_on_sync: assert property ($changed(taps_active_user) |-> sync_pulse)
		else $error("active taps changed outside sync");
endmodule // fcu_top_props

//--- fcu_host.sv
`timescale 1ns/1ps
module fcu_host (
	// Clock
	input wire logic        core_clk,
	// Register port
	output logic            reg_wr,
	output logic            reg_rd,
	output logic     [7:0]  reg_addr,
	output logic     [23:0] reg_wdata,
	input wire logic [23:0] reg_rdata
);
	// Idle port from time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 24'h000000;
	end
	// One write, released lines inverted, optional settling wait
	task automatic wr(input logic [7:0] a, input logic [23:0] dat, input bit s);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= dat;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~dat;
		if (s) repeat (fcu_pkg::WAIT_CYC + 1) @(posedge core_clk);
	endtask
	// One read, data taken at the edge where the answer is sampled
	task automatic rd(input logic [7:0] a, input bit s, output logic [23:0] dat);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge core_clk);
		dat = reg_rdata;
		if (s) repeat (fcu_pkg::WAIT_CYC + 1) @(posedge core_clk);
	endtask
endmodule // fcu_host

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        core_clk, rst, ce, reg_wr, reg_rd, reg_rvalid;
	logic        prog_filter_sel, key_open, user_taps_enable;
	logic        taps_active_user, sync_pulse, settle_busy;
	logic [7:0]  reg_addr;
	logic [23:0] reg_wdata, reg_rdata, tap_coef, d;
	logic [6:0]  tap_sel;
	logic [2:0]  filter_type;
	logic [7:0]  ra [5] = '{8'h19, 8'h1D, 8'h32, 8'h33, 8'h00};
	logic [23:0] rv [5] = '{24'h0, 24'h80, 24'h0, 24'h0, 24'h0};
	logic [5:0]  it [5] = '{6'h00, 6'h17, 6'h18, 6'h37, 6'h18};
	int          bad_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          rv_seen = 0;
	fcu_top uut (.core_clk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rvalid, .tap_sel, .tap_coef, .filter_type, .prog_filter_sel, .key_open,
		.user_taps_enable, .taps_active_user, .sync_pulse, .settle_busy);
	fcu_host u_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
	// Compare and count
	task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", n, exp, seen);
			bad_count++;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Tap fetch, answer one cycle later
	task automatic tap(input logic [6:0] s, input logic [23:0] e);
		@(posedge core_clk);
		tap_sel <= s;
		@(posedge core_clk);
		#1 chk("tap_coef", tap_coef, e);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Count read answers as they stand
	always @(posedge core_clk) begin
		rv_seen <= rv_seen + int'(reg_rvalid);
	end
	// Hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		tap_sel = 7'h00;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		// Values after reset, unmapped place included
		foreach (ra[k]) begin
			u_host.rd(ra[k], ra[k] == 8'h33, d);
			chk("reset value", d, rv[k]);
		end
		u_host.wr(8'h19, 24'h000040, 1'b0);
		#1 chk("filter_type", {21'h0, filter_type}, 24'h4);
		chk("prog_filter_sel", {23'h0, prog_filter_sel}, 24'h1);
		// Wrong second byte, then the right key
		u_host.wr(8'h34, 24'h0000AC, 1'b0);
		u_host.wr(8'h34, 24'h000012, 1'b0);
		u_host.rd(8'h34, 1'b0, d);
		chk("key bit", {23'h0, d[0]}, 24'h0);
		u_host.wr(8'h34, 24'h0000AC, 1'b0);
		u_host.wr(8'h34, 24'h000045, 1'b0);
		u_host.rd(8'h34, 1'b0, d);
		chk("key bit", {23'h0, d[0]}, 24'h1);
		// Upload: 0..23 zero, 24..55 equal shares of the total gain
		u_host.wr(8'h32, 24'h0000C0, 1'b0);
		#1 chk("settle_busy", {23'h0, settle_busy}, 24'h1);
		repeat (fcu_pkg::WAIT_CYC - 1) @(posedge core_clk);
		#1 chk("settle_busy", {23'h0, settle_busy}, 24'h1);
		@(posedge core_clk);
		#1 chk("settle_busy", {23'h0, settle_busy}, 24'h0);
		u_host.wr(8'h33, 24'h000000, 1'b1);
		for (int i = 1; i < 56; i++) begin
			u_host.wr(8'h32, {16'h0000, 8'hC0 | 8'(i)}, 1'b1);
			if (i == 24) u_host.wr(8'h33, 24'h020000, 1'b1);
		end
		u_host.wr(8'h32, 24'h000080, 1'b1);
		u_host.wr(8'h32, 24'h000000, 1'b1);
		u_host.wr(8'h33, 24'h800000, 1'b1);
		chk("user_taps_enable", {23'h0, user_taps_enable}, 24'h1);
		u_host.rd(8'h33, 1'b1, d);
		chk("data word", d, 24'h800000);
		u_host.wr(8'h34, 24'h000055, 1'b0);
		#1 chk("key_open", {23'h0, key_open}, 24'h0);
		u_host.wr(8'h33, 24'h7FFFFF, 1'b1);
		u_host.wr(8'h1D, 24'h000000, 1'b0);
		#1 chk("sync_pulse", {23'h0, sync_pulse}, 24'h1);
		chk("taps_active_user", {23'h0, taps_active_user}, 24'h1);
		tap(7'd24, 24'h020000);
		tap(7'd87, 24'h020000);
		tap(7'd23, 24'h000000);
		tap(7'd111, 24'h000000);
		// Read back with writing disabled, one index twice
		u_host.wr(8'h34, 24'h0000AC, 1'b0);
		u_host.wr(8'h34, 24'h000045, 1'b0);
		foreach (it[k]) begin
			u_host.wr(8'h32, {16'h0000, 2'b10, it[k]}, 1'b1);
			u_host.rd(8'h33, 1'b1, d);
			chk("readback", d, (it[k] >= 6'h18) ? 24'h020000 : 24'h000000);
		end
		u_host.wr(8'h32, 24'h000000, 1'b1);
		u_host.wr(8'h34, 24'h000055, 1'b0);
		chk("reg_rvalid count", 24'(rv_seen), 24'h00000D);
		print_verdict();
	end
endmodule // tb_top
bind fcu_top fcu_top_props #(.COEF_DEPTH(COEF_DEPTH)) u_props (.core_clk, .rst, .ce, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .filter_type, .prog_filter_sel, .key_open,
	.user_taps_enable, .taps_active_user, .sync_pulse, .settle_busy);
